// File: include/bbr_regs.vh
// address map and encoding constants for the bit-band alias remapper
`ifndef BBR_REGS_VH
`define BBR_REGS_VH

// region bases
`define BBR_SRAM_ALIAS_BASE   32'h22000000
`define BBR_SRAM_BAND_BASE    32'h20000000
`define BBR_PERI_ALIAS_BASE   32'h42000000
`define BBR_PERI_BAND_BASE    32'h40000000

// alias windows are 32 MB: compare address bits 31:25
`define BBR_ALIAS_HI          31
`define BBR_ALIAS_LO          25
// bit-band regions are 1 MB: byte offset is 20 bits
`define BBR_BAND_OFS_W        20

// alias offset layout: byte offset times 32 plus bit number times 4
`define BBR_BYTE_OFS_HI       24
`define BBR_BYTE_OFS_LO       5
`define BBR_BITNUM_HI         4
`define BBR_BITNUM_LO         2

// access size encoding
`define BBR_SIZE_BYTE         2'h0
`define BBR_SIZE_HALF         2'h1
`define BBR_SIZE_WORD         2'h2

`endif

// File: src/bbr_lane.v
// byte lane helper: extracts or merges one bit of a little-endian bus word
`timescale 1ns/1ps
`default_nettype none

module bbr_lane (
  // addressed bit
  input  wire [1:0]  byte_lane,
  input  wire [2:0]  bit_num,
  // data
  input  wire [31:0] rd_word,
  input  wire        new_bit,
  // results
  output wire        old_bit,
  output wire [31:0] merged_word
);

  wire [4:0]  bit_pos;
  wire [31:0] bit_mask;

  // lowest byte address carries the least significant byte
  assign bit_pos     = {byte_lane, bit_num};
  assign bit_mask    = 32'h00000001 << bit_pos;
  assign old_bit     = rd_word[bit_pos];
  assign merged_word = new_bit ? (rd_word | bit_mask) : (rd_word & ~bit_mask);

endmodule

`default_nettype wire

// File: src/bbr_remap.v
// bit-band alias remapper between the core data bus and memory
`timescale 1ns/1ps
`default_nettype none
`include "bbr_regs.vh"

// Operation
// - data accesses in SRAM alias window map onto one SRAM bit-band bit
// - data accesses in peripheral alias window map onto one peripheral bit-band bit
// - alias offset equals byte offset times 32 plus bit number times 4
// - memory access keeps the master's size: word, halfword or byte
// - alias writes run as read, single bit change, write back
// - instruction fetches to SRAM alias window pass through unremapped
// - instruction fetches to peripheral alias window are refused with an error
// - bit 0 of written value sets or clears the target bit
// - upper written bits are ignored; 0x01 and 0xFF act alike
// - alias reads return zero or one according to the target bit
// - direct accesses to bit-band regions pass through unchanged
// - little-endian byte order: lowest address holds least significant byte
module bbr_remap (
  // clock and reset
  input  wire        sys_clk,
  input  wire        srst,
  // upstream request from the core
  input  wire        up_req,
  input  wire        up_write,
  input  wire        up_fetch,
  input  wire [1:0]  up_size,
  input  wire [31:0] up_addr,
  input  wire [31:0] up_wdata,
  // upstream answer
  output wire        up_ready,
  output reg  [31:0] up_rdata_r,
  output reg         up_done_r,
  output reg         up_err_r,
  // downstream request to memory
  output reg         mem_req_r,
  output reg         mem_write_r,
  output reg  [1:0]  mem_size_r,
  output reg  [31:0] mem_addr_r,
  output reg  [31:0] mem_wdata_r,
  output reg         mem_lock_r,
  // downstream answer
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata
);

  //--------------------------------------------------------------------
  // states
  //--------------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_PASS  = 3'h1;
  localparam [2:0] ST_ARD   = 3'h2;
  localparam [2:0] ST_AWR   = 3'h3;

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg         alias_wr_r;
  reg  [1:0]  lane_r;
  reg  [2:0]  bitn_r;
  reg         newbit_r;

  //--------------------------------------------------------------------
  // address decode
  //--------------------------------------------------------------------

  // alias hit: top seven address bits match a window base
  function in_win;
    input [31:0] a;
    input [31:0] base;
    begin
      in_win = (a[`BBR_ALIAS_HI:`BBR_ALIAS_LO] == base[`BBR_ALIAS_HI:`BBR_ALIAS_LO]);
    end
  endfunction

  // band byte address from alias address: inverse of offset formula
  function [31:0] band_addr;
    input [31:0] a;
    input [31:0] base;
    begin
      band_addr = base | {12'h000, a[`BBR_BYTE_OFS_HI:`BBR_BYTE_OFS_LO]};
    end
  endfunction

  wire        hit_sram = in_win(up_addr, `BBR_SRAM_ALIAS_BASE);
  wire        hit_peri = in_win(up_addr, `BBR_PERI_ALIAS_BASE);
  wire [31:0] sram_band = band_addr(up_addr, `BBR_SRAM_BAND_BASE);
  wire [31:0] peri_band = band_addr(up_addr, `BBR_PERI_BAND_BASE);
  wire [31:0] tgt_byte  = hit_sram ? sram_band : peri_band;
  // fetches from the SRAM window are not remapped
  wire        do_alias  = (hit_sram & ~up_fetch) | (hit_peri & ~up_fetch);
  wire        do_refuse = hit_peri & up_fetch;
  // memory address keeps size alignment of the master's access
  reg  [31:0] tgt_aligned;

  always @* begin
    tgt_aligned = tgt_byte;
    if (up_size == `BBR_SIZE_WORD) begin
      tgt_aligned = {tgt_byte[31:2], 2'h0};
    end else if (up_size == `BBR_SIZE_HALF) begin
      tgt_aligned = {tgt_byte[31:1], 1'h0};
    end
  end

  //--------------------------------------------------------------------
  // bit extract and merge
  //--------------------------------------------------------------------
  wire        old_bit;
  wire [31:0] merged;

  bbr_lane u_lane (
    .byte_lane   (lane_r),
    .bit_num     (bitn_r),
    .rd_word     (mem_rdata),
    .new_bit     (newbit_r),
    .old_bit     (old_bit),
    .merged_word (merged)
  );

  assign up_ready = (state_r == ST_IDLE);

  //--------------------------------------------------------------------
  // control state machine
  //--------------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (up_req & ~do_refuse) begin
          state_nxt = do_alias ? ST_ARD : ST_PASS;
        end
      end
      ST_PASS: begin
        if (mem_ack) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_ARD: begin
        if (mem_ack) begin
          state_nxt = alias_wr_r ? ST_AWR : ST_IDLE;
        end
      end
      ST_AWR: begin
        if (mem_ack) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // datapath registers
  always @(posedge sys_clk) begin
    if (srst) begin
      state_r     <= ST_IDLE;
      alias_wr_r  <= 1'b0;
      lane_r      <= 2'h0;
      bitn_r      <= 3'h0;
      newbit_r    <= 1'b0;
      up_rdata_r  <= 32'h00000000;
      up_done_r   <= 1'b0;
      up_err_r    <= 1'b0;
      mem_req_r   <= 1'b0;
      mem_write_r <= 1'b0;
      mem_size_r  <= `BBR_SIZE_WORD;
      mem_addr_r  <= 32'h00000000;
      mem_wdata_r <= 32'h00000000;
      mem_lock_r  <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      up_done_r <= 1'b0;
      up_err_r  <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (up_req & do_refuse) begin
            up_done_r <= 1'b1;
            up_err_r  <= 1'b1;
          end else if (up_req & do_alias) begin
            alias_wr_r  <= up_write;
            lane_r      <= tgt_byte[1:0];
            bitn_r      <= up_addr[`BBR_BITNUM_HI:`BBR_BITNUM_LO];
            newbit_r    <= up_wdata[0];
            mem_req_r   <= 1'b1;
            mem_write_r <= 1'b0;
            mem_size_r  <= up_size;
            mem_addr_r  <= tgt_aligned;
            mem_lock_r  <= up_write;
          end else if (up_req) begin
            mem_req_r   <= 1'b1;
            mem_write_r <= up_write;
            mem_size_r  <= up_size;
            mem_addr_r  <= up_addr;
            mem_wdata_r <= up_wdata;
          end
        end
        ST_PASS: begin
          if (mem_ack) begin
            mem_req_r  <= 1'b0;
            up_done_r  <= 1'b1;
            up_rdata_r <= mem_rdata;
          end
        end
        ST_ARD: begin
          if (mem_ack & alias_wr_r) begin
            mem_write_r <= 1'b1;
            mem_wdata_r <= merged;
          end else if (mem_ack) begin
            mem_req_r  <= 1'b0;
            up_done_r  <= 1'b1;
            up_rdata_r <= {31'h00000000, old_bit};
          end
        end
        ST_AWR: begin
          if (mem_ack) begin
            mem_req_r   <= 1'b0;
            mem_write_r <= 1'b0;
            mem_lock_r  <= 1'b0;
            up_done_r   <= 1'b1;
            up_rdata_r  <= 32'h00000000;
          end
        end
        default: begin
          mem_req_r <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// File: verification/bbr_mem_model.sv
// memory model behind the remapper's downstream port
`timescale 1ns/1ps
`default_nettype none
module bbr_mem_model (
  // request
  input  wire logic        sys_clk,
  input  wire logic        slow,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  // answer
  output logic             ack,
  output logic [31:0]      rdata
);
  logic [31:0] mem [0:15];
  logic [2:0]  wait_r = 3'h0;
  wire  [3:0]  idx = {addr[30], addr[4:2]};
  // outside an ack the data is inverted so a stale value never matches
  assign rdata = ack ? mem[idx] : ~mem[idx];
  initial for (int i = 0; i < 16; i++) mem[i] = 32'h0;
  // ack after zero or three wait cycles; whole word stored on ack
  always @(posedge sys_clk) begin
    ack <= 1'b0;
    if (req && !ack && wait_r == (slow ? 3'h3 : 3'h0)) begin
      ack <= 1'b1;
      wait_r <= 3'h0;
      if (wr)
        mem[idx] <= wdata;
    end else if (req && !ack)
      wait_r <= wait_r + 3'h1;
  end
endmodule
`default_nettype wire

// File: verification/bbr_remap_sva.sv
// port assertions for the remapper
`timescale 1ns/1ps
`default_nettype none
module bbr_remap_sva (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        srst,
  // upstream request
  input wire logic        up_req,
  input wire logic        up_write,
  input wire logic        up_fetch,
  input wire logic [1:0]  up_size,
  input wire logic [31:0] up_addr,
  input wire logic [31:0] up_wdata,
  // upstream answer
  input wire logic        up_ready,
  input wire logic        up_done_r,
  input wire logic        up_err_r,
  input wire logic [31:0] up_rdata_r,
  // downstream request
  input wire logic        mem_req_r,
  input wire logic        mem_write_r,
  input wire logic        mem_lock_r,
  input wire logic [1:0]  mem_size_r,
  input wire logic [31:0] mem_addr_r,
  input wire logic [31:0] mem_wdata_r,
  // downstream answer
  input wire logic        mem_ack,
  input wire logic [31:0] mem_rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire tk = up_req && up_ready;
  wire pa = up_addr[31:25] == 7'h21;
  wire da = (pa || up_addr[31:25] == 7'h11) && !up_fetch;
  logic [4:0] pos_r;
  logic       alias_r;
  logic       bit_r;
  // bit position (lane * 8 + bit) and kind of the taken request
  always @(posedge sys_clk) if (tk) begin
    pos_r <= up_addr[6:2];
    alias_r <= da;
    bit_r <= up_wdata[0];
  end
  pass_fields_a: assert property (tk && !da && !(up_fetch && pa) |=> mem_req_r
    && {mem_write_r, mem_size_r, mem_addr_r} == $past({up_write, up_size, up_addr}))
    else $error("direct access altered");
  alias_map_a: assert property (tk && da |=> mem_req_r && !mem_write_r
    && mem_addr_r[31:2] == {$past(up_addr[30]) ? 12'h400 : 12'h200, $past(up_addr[24:7])}
    && mem_size_r == $past(up_size)) else $error("alias address wrong");
  fetch_refuse_a: assert property (tk && up_fetch && pa |=> up_done_r && up_err_r
    && !mem_req_r) else $error("peripheral alias fetch not refused");
  rmw_merge_a: assert property (mem_req_r && mem_lock_r && !mem_write_r && mem_ack
    |=> mem_req_r && mem_write_r && mem_lock_r && $stable(mem_addr_r) && mem_wdata_r ==
    ($past(mem_rdata) & ~(32'h1 << pos_r) | ({31'h0, bit_r} << pos_r))) else $error("bad merge");
  rmw_close_a: assert property (mem_req_r && mem_lock_r && mem_write_r && mem_ack
    |=> !mem_req_r && !mem_lock_r && up_done_r) else $error("write half not closed");
  alias_read_a: assert property (mem_req_r && !mem_write_r && !mem_lock_r && mem_ack
    && alias_r |=> up_done_r && up_rdata_r == ($past(mem_rdata >> pos_r) & 32'h1))
    else $error("alias read value wrong");
  pass_read_a: assert property (mem_req_r && !mem_write_r && mem_ack && !alias_r
    |=> up_done_r && up_rdata_r == $past(mem_rdata)) else $error("direct read altered");
  busy_block_a: assert property (mem_req_r |-> !up_ready) else $error("taken while busy");
  cover property (tk && da && up_write);
  cover property (tk && up_fetch && pa);
  cover property (mem_ack && mem_write_r && mem_lock_r);
  cover property (tk && da && !up_write && up_size == 2'h1);
endmodule
`default_nettype wire

// File: verification/bbr_remap_bench.sv
// self-checking bench for the bit-band alias remapper
`timescale 1ns/1ps
`default_nettype none
module bbr_remap_bench;
  logic        sys_clk = 1'b0, srst = 1'b1, up_req = 1'b0, up_write = 1'b0;
  logic        up_fetch = 1'b0, slow = 1'b0, er;
  logic [1:0]  up_size = 2'h2;
  logic [31:0] up_addr = 32'h0, up_wdata = 32'h0, rd;
  wire         up_ready, up_done_r, up_err_r, mem_req_r, mem_write_r, mem_lock_r, mem_ack;
  wire  [1:0]  mem_size_r;
  wire  [31:0] up_rdata_r, mem_addr_r, mem_wdata_r, mem_rdata;
  int          bad_count = 0, total_checks = 0;
  bbr_remap DUT (.sys_clk, .srst, .up_req, .up_write, .up_fetch, .up_size, .up_addr,
    .up_wdata, .up_ready, .up_rdata_r, .up_done_r, .up_err_r, .mem_req_r, .mem_write_r,
    .mem_size_r, .mem_addr_r, .mem_wdata_r, .mem_lock_r, .mem_ack, .mem_rdata);
  bbr_mem_model u_mem (.sys_clk, .slow, .req(mem_req_r), .wr(mem_write_r),
    .addr(mem_addr_r), .wdata(mem_wdata_r), .ack(mem_ack), .rdata(mem_rdata));
  always #5 sys_clk = ~sys_clk;
  task close_out;
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held over the edge that takes it, then a bounded wait for done
  task xfer(input logic w, f, input logic [1:0] s, input logic [31:0] a, d);
    int n;
    n = 0;
    {up_req, up_write, up_fetch, up_size, up_addr, up_wdata} = {1'b1, w, f, s, a, d};
    @(posedge sys_clk);
    #1 up_req = 1'b0;
    while (up_done_r !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk("done", {31'h0, n < 40}, 32'h1);
    rd = up_rdata_r;
    er = up_err_r;
    @(posedge sys_clk);
    #1;
  endtask
  // direct write and read back in the sram band
  task t_direct;
    xfer(1, 0, 2'h2, 32'h20000004, 32'h84210F0F);
    xfer(0, 0, 2'h2, 32'h20000004, 32'h0);
    chk("direct", rd, 32'h84210F0F);
  endtask
  // alias of byte 5 bit 3 is word bit 11; upper written bits ignored
  task t_alias;
    xfer(1, 0, 2'h2, 32'h220000AC, 32'hFE);
    xfer(0, 0, 2'h2, 32'h20000004, 32'h0);
    chk("clear", rd, 32'h8421070F);
    xfer(0, 0, 2'h2, 32'h220000AC, 32'h0);
    chk("rd0", rd, 32'h0);
    xfer(1, 0, 2'h2, 32'h220000AC, 32'hFF);
    xfer(0, 0, 2'h0, 32'h220000AC, 32'h0);
    chk("rd1", rd, 32'h1);
    xfer(0, 0, 2'h2, 32'h20000004, 32'h0);
    chk("set", rd, 32'h84210F0F);
  endtask
  // slow memory: peripheral alias byte write sets bit 7 of band word 8
  task t_peri;
    slow = 1'b1;
    xfer(1, 0, 2'h2, 32'h40000008, 32'h0);
    xfer(1, 0, 2'h0, 32'h4200011C, 32'h3);
    xfer(0, 0, 2'h2, 32'h40000008, 32'h0);
    chk("peri", rd, 32'h80);
    xfer(0, 0, 2'h1, 32'h4200011C, 32'h0);
    chk("peri half", rd, 32'h1);
    slow = 1'b0;
  endtask
  // fetches: refused in the peripheral alias, raw in the sram alias
  task t_fetch;
    xfer(0, 1, 2'h2, 32'h4200011C, 32'h0);
    chk("refuse", {31'h0, er}, 32'h1);
    xfer(0, 1, 2'h2, 32'h22000084, 32'h0);
    chk("raw", rd, 32'h84210F0F);
    chk("raw err", {31'h0, er}, 32'h0);
  endtask
  // reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 srst = 1'b0;
    t_direct;
    t_alias;
    t_peri;
    t_fetch;
    close_out;
  end
  // watchdog against a hung handshake
  initial begin
    #20000;
    bad_count++;
    close_out;
  end
endmodule
bind bbr_remap bbr_remap_sva u_sva (.sys_clk, .srst, .up_req, .up_write, .up_fetch,
  .up_ready, .up_done_r, .up_err_r, .mem_req_r, .mem_write_r, .mem_lock_r, .mem_ack,
  .up_size, .mem_size_r, .up_addr, .up_wdata, .up_rdata_r, .mem_addr_r, .mem_wdata_r,
  .mem_rdata);
`default_nettype wire
